// >>> pkg/pmc_pkg.sv
package pmc_pkg;
    // configuration offsets (capability dword holds A0h..A3h; control/status word at A4h)
    localparam logic [7:0] CAP_ID_OFS = 8'hA0;
    localparam logic [7:0] NEXT_LINK_OFS = 8'hA1;
    localparam logic [7:0] PWR_CAP_OFS = 8'hA2;
    localparam logic [7:0] PM_CSR_OFS = 8'hA4;
    // reset and fixed values
    localparam logic [7:0] CAP_ID_VAL = 8'h01;
    localparam logic [7:0] NEXT_LINK_VAL = 8'h00;
    localparam logic [15:0] PWR_CAP_RST = 16'hFE11;
    // field positions (capability word; wake enable in the control/status word) and function count
    localparam int D3COLD_WAKE_BIT = 15;
    localparam int AUX_POWER_BIT = 4;
    localparam int BUS_CLOCK_BIT = 3;
    localparam int WAKE_ENABLE_BIT = 8;
    localparam int NUM_FUNCS = 2;
endpackage : pmc_pkg

// >>> hdl/pmc_func_cap.sv
`timescale 1ns/10ps
// one function's writable D3cold wake bit of the capability word
module pmc_func_cap (
    // clock and resets
    input wire logic core_clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire logic bus_reset_pin,
    // control
    input wire logic wake_enable_bit,
    input wire logic wr_hi_byte,
    input wire logic wr_d3cold_val,
    // state
    output logic d3cold_wake_q
);
    logic d3cold_wake_d;

    always_comb begin
        d3cold_wake_d = d3cold_wake_q;
        if (sys_rst || (bus_reset_pin && !wake_enable_bit)) begin
            d3cold_wake_d = pmc_pkg::PWR_CAP_RST[pmc_pkg::D3COLD_WAKE_BIT];
        end else if (wr_hi_byte) begin
            d3cold_wake_d = wr_d3cold_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            d3cold_wake_q <= d3cold_wake_d;
        end
    end

    sticky_rst_a: assert property (@(posedge core_clk)
        clk_en && bus_reset_pin && wake_enable_bit && !sys_rst && !wr_hi_byte
        |=> d3cold_wake_q == $past(d3cold_wake_q))
        else $error("bus reset touched wake bit");
    glob_rst_a: assert property (@(posedge core_clk) clk_en && sys_rst |=> d3cold_wake_q)
        else $error("global reset did not set wake bit");
endmodule : pmc_func_cap

// >>> hdl/pmc_cap_regs.sv
`timescale 1ns/10ps
module pmc_cap_regs #(
    parameter int FUNCS = pmc_pkg::NUM_FUNCS
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire logic bus_reset_pin,
    // configuration access (dword address bits 7:2)
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [0:0] cfg_func,
    input wire logic [7:2] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    // wake enable per function, from control/status register
    input wire logic [1:0] wake_enable_bit,
    // read answer
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid
);
    // refuse function counts the select and wake inputs cannot serve
    generate
        if (FUNCS < 1 || FUNCS > 2) begin : g_bad_funcs
            $error("FUNCS must be 1 or 2");
        end
    endgenerate

    logic [1:0] d3cold_q;
    logic [1:0] wr_hi;
    logic [31:0] cfg_rdata_d;
    logic cfg_rvalid_d;

    function automatic logic hits_cap(input logic [7:2] a);
        hits_cap = (a == pmc_pkg::CAP_ID_OFS[7:2]);
    endfunction : hits_cap

    function automatic logic [15:0] cap_word(input logic d3c);
        cap_word = pmc_pkg::PWR_CAP_RST;
        cap_word[pmc_pkg::D3COLD_WAKE_BIT] = d3c;
        cap_word[pmc_pkg::AUX_POWER_BIT] = d3c;
    endfunction : cap_word

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_func
            if (g < FUNCS) begin : g_on
                // only byte A3h carries a writable bit
                assign wr_hi[g] = cfg_wr && cfg_be[3] && hits_cap(cfg_addr) && (cfg_func == 1'(g));
                pmc_func_cap u_cap (
                    .core_clk(core_clk),
                    .clk_en(clk_en),
                    .sys_rst(sys_rst),
                    .bus_reset_pin(bus_reset_pin),
                    .wake_enable_bit(wake_enable_bit[g]),
                    .wr_hi_byte(wr_hi[g]),
                    .wr_d3cold_val(cfg_wdata[16 + pmc_pkg::D3COLD_WAKE_BIT]),
                    .d3cold_wake_q(d3cold_q[g])
                );
            end else begin : g_off
                assign wr_hi[g] = 1'b0;
                assign d3cold_q[g] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        cfg_rdata_d = 32'h0000_0000;
        cfg_rvalid_d = 1'b0;
        if (cfg_rd && !sys_rst) begin
            cfg_rvalid_d = 1'b1;
            if (hits_cap(cfg_addr) && (int'(cfg_func) < FUNCS)) begin
                cfg_rdata_d = {cap_word(d3cold_q[cfg_func]), pmc_pkg::NEXT_LINK_VAL, pmc_pkg::CAP_ID_VAL};
            end
        end
    end

    // reset reaches the answer through the next values, so a low enable freezes it too
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            cfg_rdata <= cfg_rdata_d;
            cfg_rvalid <= cfg_rvalid_d;
        end
    end

    // capability dword reads, function 0 and function 1
    sequence cap_read_s;
        clk_en && !sys_rst && cfg_rd && hits_cap(cfg_addr) && cfg_func == 1'b0;
    endsequence

    sequence cap_read_f1_s;
        clk_en && !sys_rst && cfg_rd && hits_cap(cfg_addr) && cfg_func == 1'b1 && FUNCS == 2;
    endsequence

    // top byte written, one quiet cycle, then read back
    sequence wake_write_s;
        clk_en && wr_hi[0] && !bus_reset_pin;
    endsequence

    sequence wake_readback_s;
        wake_write_s ##1 (clk_en && !cfg_wr && !bus_reset_pin) ##1 cap_read_s;
    endsequence

    id_read_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[15:0] == 16'h0001)
        else $error("id or link wrong");

    link_zero_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[15:8] == 8'h00)
        else $error("next link not zero");

    fixed_bits_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[30:16] == 15'h7E11 || cfg_rdata[30:16] == 15'h7E01)
        else $error("fixed capability bits wrong");

    wake_states_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[30:27] == 4'hF)
        else $error("wake state bits not all one");

    state_two_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[26])
        else $error("state two support bit clear");

    state_one_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[25])
        else $error("state one support bit clear");

    reserved_zero_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[24:22] == 3'h0)
        else $error("reserved bits not zero");

    dsi_zero_a: assert property (@(posedge core_clk)
        cap_read_s |=> !cfg_rdata[21])
        else $error("specific init flag set");

    aux_track_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[20] == cfg_rdata[31])
        else $error("aux flag set without d3cold wake");

    bus_clock_a: assert property (@(posedge core_clk)
        cap_read_s |=> !cfg_rdata[19])
        else $error("bus clock flag set");

    version_a: assert property (@(posedge core_clk)
        cap_read_s |=> cfg_rdata[18:16] == 3'h1)
        else $error("version field wrong");

    f1_fixed_a: assert property (@(posedge core_clk)
        cap_read_f1_s |=> cfg_rdata[30:21] == 10'h3F0)
        else $error("second function fixed bits wrong");

    f1_id_a: assert property (@(posedge core_clk)
        cap_read_f1_s |=> cfg_rdata[15:0] == 16'h0001 && cfg_rdata[20] == cfg_rdata[31])
        else $error("second function id or aux wrong");

    write_take_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wake_readback_s |=> cfg_rdata[31] == $past(cfg_wdata[31], 3))
        else $error("wake bit write lost");

    wake_hold_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && !bus_reset_pin && !wr_hi[0] |=> $stable(d3cold_q[0]))
        else $error("wake bit changed without cause");

    func_isolate_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && !bus_reset_pin && wr_hi[0] |=> $stable(d3cold_q[1]))
        else $error("write reached the other function");

    glob_wake_a: assert property (@(posedge core_clk)
        clk_en && sys_rst |=> d3cold_q[0])
        else $error("global reset left wake bit clear");

    bus_rst_wake_a: assert property (@(posedge core_clk)
        clk_en && bus_reset_pin && !wake_enable_bit[0] |=> d3cold_q[0])
        else $error("bus reset did not restore wake bit");

    wake_gate_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && bus_reset_pin && wake_enable_bit[1] && !wr_hi[1] |=> $stable(d3cold_q[1]))
        else $error("bus reset ignored wake enable");

    ro_write_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && !bus_reset_pin && cfg_wr && !cfg_be[3] |=> $stable(d3cold_q))
        else $error("write without top byte changed state");

    rvalid_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && cfg_rd |=> cfg_rvalid)
        else $error("read not answered");

    rvalid_pulse_a: assert property (@(posedge core_clk)
        clk_en && !cfg_rd |=> !cfg_rvalid)
        else $error("answer without read");

    idle_zero_a: assert property (@(posedge core_clk)
        clk_en && !cfg_rd |=> cfg_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");

    unmapped_a: assert property (@(posedge core_clk)
        clk_en && !sys_rst && cfg_rd && !hits_cap(cfg_addr) |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    reset_quiet_a: assert property (@(posedge core_clk)
        clk_en && sys_rst |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("read answered during reset");

    freeze_out_a: assert property (@(posedge core_clk)
        !clk_en |=> $stable(cfg_rdata) && $stable(cfg_rvalid))
        else $error("answer moved with enable low");

    freeze_wake_a: assert property (@(posedge core_clk)
        !clk_en |=> $stable(d3cold_q))
        else $error("wake bits moved with enable low");
endmodule : pmc_cap_regs

// >>> verification/pmc_host_model.sv
`timescale 1ns/10ps
module pmc_host_model (
    // clock
    input wire logic core_clk,
    // configuration requests
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [0:0] cfg_func,
    output logic [7:2] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // read answer
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial begin
        {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
    end
    task automatic wr(input logic [0:0] f, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        {cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {1'b1, f, 6'h28, be, d};
        @(negedge core_clk);
        cfg_wr = 1'b0;
    endtask : wr
    // answer stands one cycle, taken at the falling edge after the request
    task automatic rd(input logic [0:0] f, input logic [7:2] a, output logic [31:0] d, output logic v);
        @(negedge core_clk);
        {cfg_rd, cfg_func, cfg_addr} = {1'b1, f, a};
        @(negedge core_clk);
        cfg_rd = 1'b0;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask : rd
endmodule : pmc_host_model

// >>> verification/pmc_cap_regs_tb_top.sv
`timescale 1ns/10ps
module pmc_cap_regs_tb_top;
    logic core_clk, clk_en, sys_rst, bus_reset_pin, cfg_rd, cfg_wr, cfg_rvalid;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [0:0] cfg_func;
    logic [7:2] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [1:0] wake_enable_bit;
    int miscompares = 0;
    int num_checks = 0;
    pmc_cap_regs uut (.core_clk(core_clk), .clk_en(clk_en), .sys_rst(sys_rst), .bus_reset_pin(bus_reset_pin),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .wake_enable_bit(wake_enable_bit), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    pmc_host_model host (.core_clk(core_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            $display("Error at %0t: seen %h expected %h", $time, s, e);
            miscompares++;
        end
    endtask : chk
    task automatic rc(input logic [0:0] f, input logic [7:2] a, input logic [31:0] e);
        logic [31:0] d;
        logic v;
        host.rd(f, a, d, v);
        chk({31'h0, v}, 32'h1);
        chk(d, e);
    endtask : rc
    task automatic final_report;
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        bus_reset_pin = 1'b0;
        wake_enable_bit = 2'b00;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        rc(1'b0, 6'h28, 32'hFE11_0001);
        rc(1'b1, 6'h28, 32'hFE11_0001);
        rc(1'b0, 6'h29, 32'h0000_0000);
        // firmware without aux power clears bit 15
        host.wr(1'b0, 4'hF, 32'h7FFF_FFFF);
        rc(1'b0, 6'h28, 32'h7E01_0001);
        rc(1'b1, 6'h28, 32'hFE11_0001);
        host.wr(1'b0, 4'h7, 32'hFFFF_FFFF);
        rc(1'b0, 6'h28, 32'h7E01_0001);
        host.wr(1'b0, 4'h8, 32'h8000_0000);
        rc(1'b0, 6'h28, 32'hFE11_0001);
        host.wr(1'b0, 4'h8, 32'h0000_0000);
        host.wr(1'b1, 4'h8, 32'h0000_0000);
        wake_enable_bit = 2'b10;
        @(negedge core_clk) bus_reset_pin = 1'b1;
        @(negedge core_clk) bus_reset_pin = 1'b0;
        rc(1'b0, 6'h28, 32'hFE11_0001);
        rc(1'b1, 6'h28, 32'h7E01_0001);
        // enable low: write not taken, last answer frozen
        clk_en = 1'b0;
        host.wr(1'b0, 4'h8, 32'h0000_0000);
        host.rd(1'b0, 6'h28, rd_data, rd_ok);
        clk_en = 1'b1;
        chk(rd_data, 32'h7E01_0001);
        chk({31'h0, rd_ok}, 32'h1);
        rc(1'b0, 6'h28, 32'hFE11_0001);
        // global reset in mid-run, read during it is not answered
        sys_rst = 1'b1;
        host.rd(1'b1, 6'h28, rd_data, rd_ok);
        sys_rst = 1'b0;
        chk(rd_data, 32'h0000_0000);
        chk({31'h0, rd_ok}, 32'h0);
        rc(1'b1, 6'h28, 32'hFE11_0001);
        final_report();
    end
endmodule : pmc_cap_regs_tb_top
